// ### rtl/fcm_mapper.sv
// fractional core frame mapper: application bytes to per-pair line bytes and back
// Notes on behaviour
// - core frame spread over two or three pairs
// - application frame placed bytewise at fixed position
// - bytes without data carry all ones
// - unequipped pairs regenerated as all ones at receiver
// - core to pair distribution same as full system
// - framing slot first payload byte of core frame
// - own share of transfer delay under budget
// - slot sixteen reserved, data skips it, rest ones
module fcm_mapper #(
    parameter int FIFO_DEPTH = 32,
    parameter int DATA_W     = 8
) (
    // clock and reset
    input  wire logic                            SYS_CLK_IN,
    input  wire logic                            RST_IN,
    // configuration from local control logic
    input  wire logic                            MAP_ENABLE_IN,
    input  wire logic                            RATE_SEL_IN,
    input  wire logic [fcm_pkg::PAIRS_MAX-1:0]   PAIR_EQUIP_IN,
    input  wire logic [4:0]                      DATA_SLOTS_IN,
    // application side
    input  wire logic [DATA_W-1:0]               FRAMING_TS_IN,
    input  wire logic [DATA_W-1:0]               USER_DATA_IN,
    input  wire logic                            USER_VALID_IN,
    output logic                                 USER_READY_OUT,
    // core byte timing
    output logic                                 BYTE_TICK_OUT,
    output logic [1:0]                           PAIR_SEL_OUT,
    // transmit towards the line transceivers
    output logic [fcm_pkg::PAIRS_MAX*DATA_W-1:0] LINE_DATA_OUT,
    output logic [fcm_pkg::PAIRS_MAX-1:0]        LINE_VALID_OUT,
    output logic                                 LINE_FIRST_OUT,
    // receive from the line transceivers
    input  wire logic [fcm_pkg::PAIRS_MAX*DATA_W-1:0] RX_LINE_DATA_IN,
    output logic [DATA_W-1:0]                    RX_CORE_DATA_OUT,
    output logic                                 RX_CORE_VALID_OUT,
    output logic                                 RX_CORE_FIRST_OUT,
    // status
    output logic                                 UNDERRUN_OUT
);

    // timing constants at register width
    localparam logic [14:0] FRAME_W = 15'(fcm_pkg::FRAME_CYC);
    localparam logic [14:0] STEP_W  = 15'(fcm_pkg::CORE_BYTES);
    localparam logic [7:0]  CORE_LAST = 8'(fcm_pkg::CORE_BYTES - 1);
    localparam logic [5:0]  SUB_LAST  = 6'(fcm_pkg::SUB_BYTES - 1);
    localparam logic [5:0]  APP_END   = 6'(fcm_pkg::APP_BYTES);
    localparam logic [1:0]  LAST_784  = 2'(fcm_pkg::PAIRS_784 - 1);
    localparam logic [1:0]  LAST_1168 = 2'(fcm_pkg::PAIRS_1168 - 1);

    // the pipeline must fit the unit's share of the delay budget
    if (fcm_pkg::PIPE_CYC > fcm_pkg::DELAY_TERM_CYC)
    begin : g_bad_delay
        $error("fcm_mapper pipeline exceeds the delay share");
    end
    // the byte spreader gives at most one tick per cycle, so a frame needs at least 144 cycles
    if (DATA_W != 8 || FIFO_DEPTH < 2 || fcm_pkg::CORE_BYTES > fcm_pkg::FRAME_CYC)
    begin : g_bad_param
        $error("fcm_mapper parameters out of range");
    end

    // classify one application time slot against the data slot count
    function automatic fcm_pkg::fcm_slot_t slot_kind(input logic [5:0] pos, input logic [4:0] n);
        logic [4:0] ts;
        logic [4:0] nn;
        ts = pos[4:0];
        nn = (n > fcm_pkg::SLOTS_MAX) ? fcm_pkg::SLOTS_MAX : n;
        if (pos >= APP_END)
            slot_kind = fcm_pkg::SLOT_FILL;
        else if (ts == fcm_pkg::TS_FRAMING)
            slot_kind = fcm_pkg::SLOT_FRAMING;
        else if (ts == fcm_pkg::TS_SIGNAL)
            slot_kind = fcm_pkg::SLOT_FILL;
        else if (nn <= fcm_pkg::TS_LOW_END)
            slot_kind = (ts <= nn) ? fcm_pkg::SLOT_DATA : fcm_pkg::SLOT_FILL;
        else
            slot_kind = ({1'b0, ts} <= {1'b0, nn} + 6'h01) ? fcm_pkg::SLOT_DATA
                                                          : fcm_pkg::SLOT_FILL;
    endfunction

    // pick the byte of one pair from a flat bus
    function automatic logic [7:0] pair_byte(input logic [23:0] bus, input logic [1:0] p);
        pair_byte = bus[8*p +: 8];
    endfunction

    // user data buffer
    logic [DATA_W-1:0]       fifo_data;      // head word
    logic                    fifo_valid;     // head word present
    logic                    fifo_pop;       // head word used in a data slot

    fcm_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (RST_IN),
        .in_data_in    (USER_DATA_IN),
        .in_valid_in   (USER_VALID_IN),
        .in_ready_out  (USER_READY_OUT),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    // timing and position state
    fcm_pkg::fcm_state_t state_reg;          // idle or mapping
    fcm_pkg::fcm_state_t state_next;
    logic [13:0]         acc_reg;            // fractional byte rate accumulator
    logic [13:0]         acc_next;
    logic [7:0]          idx_reg;            // byte index within core frame
    logic [7:0]          idx_next;
    logic [5:0]          pos_reg;            // byte index within sub-block
    logic [5:0]          pos_next;
    logic [1:0]          pair_reg;           // pair that takes the current byte
    logic [1:0]          pair_next;
    // scratch for the current byte
    logic [14:0]         acc_sum;            // accumulator plus step
    logic                tick;               // one core byte time elapsed
    logic                run_tick;           // a byte is mapped this cycle
    logic [1:0]          pair_last;          // highest pair index at this rate
    fcm_pkg::fcm_slot_t  kind;               // content of the current slot
    logic [7:0]          tx_byte;            // byte placed into the core frame

    // output registers
    logic [7:0]          line_reg [fcm_pkg::PAIRS_MAX];
    logic [7:0]          line_next [fcm_pkg::PAIRS_MAX];
    logic [2:0]          lvalid_reg;
    logic [2:0]          lvalid_next;
    logic                lfirst_reg;
    logic                lfirst_next;
    logic [7:0]          rx_reg;
    logic [7:0]          rx_next;
    logic                rvalid_reg;
    logic                rvalid_next;
    logic                rfirst_reg;
    logic                rfirst_next;
    logic                under_reg;
    logic                under_next;

    // spread 144 byte ticks evenly over each 10000-cycle frame
    always_comb
    begin
        acc_sum  = {1'b0, acc_reg} + STEP_W;
        tick     = (acc_sum >= FRAME_W);
        acc_next = tick ? 14'(acc_sum - FRAME_W) : acc_sum[13:0];
    end

    // position counters and slot content
    always_comb
    begin
        state_next = state_reg;
        idx_next   = idx_reg;
        pos_next   = pos_reg;
        pair_next  = pair_reg;
        // pair count follows the line rate only, never the equipment
        pair_last  = (RATE_SEL_IN == fcm_pkg::RATE_1168) ? LAST_1168 : LAST_784;
        run_tick   = tick & MAP_ENABLE_IN;
        kind       = slot_kind(pos_reg, DATA_SLOTS_IN);
        fifo_pop   = 1'b0;
        case (kind)
            fcm_pkg::SLOT_FRAMING: tx_byte = FRAMING_TS_IN;
            fcm_pkg::SLOT_DATA:    tx_byte = fifo_valid ? fifo_data : fcm_pkg::ALL_ONES;
            default:               tx_byte = fcm_pkg::ALL_ONES;
        endcase
        case (state_reg)
            fcm_pkg::ST_IDLE:
            begin
                // a new frame always starts at byte zero, so slot zero leads
                idx_next  = '0;
                pos_next  = '0;
                pair_next = '0;
                if (run_tick)
                begin
                    state_next = fcm_pkg::ST_RUN;
                end
            end
            fcm_pkg::ST_RUN:
            begin
                if (!MAP_ENABLE_IN)
                begin
                    // stopping drops the partial frame; restart realigns
                    state_next = fcm_pkg::ST_IDLE;
                    idx_next   = '0;
                    pos_next   = '0;
                    pair_next  = '0;
                end
            end
            default:
            begin
                state_next = fcm_pkg::ST_IDLE;
            end
        endcase
        if (run_tick)
        begin
            fifo_pop  = (kind == fcm_pkg::SLOT_DATA) & fifo_valid;
            // fixed layout keeps each slot at the same place every frame
            idx_next  = (idx_reg == CORE_LAST) ? 8'h00 : idx_reg + 8'h01;
            pos_next  = (pos_reg == SUB_LAST || idx_reg == CORE_LAST) ? 6'h00 : pos_reg + 6'h01;
            pair_next = (pair_reg >= pair_last || idx_reg == CORE_LAST) ? 2'h0 : pair_reg + 2'h1;
        end
    end

    // line and receive output values
    always_comb
    begin
        for (int p = 0; p < fcm_pkg::PAIRS_MAX; p++)
        begin
            line_next[p] = line_reg[p];
        end
        lvalid_next = '0;
        lfirst_next = 1'b0;
        rx_next     = rx_reg;
        rvalid_next = 1'b0;
        rfirst_next = 1'b0;
        under_next  = 1'b0;
        if (run_tick)
        begin
            line_next[pair_reg] = tx_byte;
            // an unequipped pair gets no strobe; its byte still carries the slot content
            lvalid_next = PAIR_EQUIP_IN & (3'b001 << pair_reg);
            lfirst_next = (idx_reg == '0);
            under_next  = (kind == fcm_pkg::SLOT_DATA) & ~fifo_valid;
            // regenerate ones for a pair that is not fitted, whatever the others do
            rx_next     = PAIR_EQUIP_IN[pair_reg] ? pair_byte(RX_LINE_DATA_IN, pair_reg)
                                                  : fcm_pkg::ALL_ONES;
            rvalid_next = 1'b1;
            rfirst_next = (idx_reg == '0);
        end
    end

    // register every group
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            state_reg  <= fcm_pkg::ST_IDLE;
            acc_reg    <= '0;
            idx_reg    <= '0;
            pos_reg    <= '0;
            pair_reg   <= '0;
            for (int p = 0; p < fcm_pkg::PAIRS_MAX; p++)
            begin
                line_reg[p] <= fcm_pkg::ALL_ONES;
            end
            lvalid_reg <= '0;
            lfirst_reg <= 1'b0;
            rx_reg     <= fcm_pkg::ALL_ONES;
            rvalid_reg <= 1'b0;
            rfirst_reg <= 1'b0;
            under_reg  <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            acc_reg    <= acc_next;
            idx_reg    <= idx_next;
            pos_reg    <= pos_next;
            pair_reg   <= pair_next;
            for (int p = 0; p < fcm_pkg::PAIRS_MAX; p++)
            begin
                line_reg[p] <= line_next[p];
            end
            lvalid_reg <= lvalid_next;
            lfirst_reg <= lfirst_next;
            rx_reg     <= rx_next;
            rvalid_reg <= rvalid_next;
            rfirst_reg <= rfirst_next;
            under_reg  <= under_next;
        end
    end

    // flatten the per-pair line bytes
    for (genvar g = 0; g < fcm_pkg::PAIRS_MAX; g++)
    begin : g_line
        assign LINE_DATA_OUT[8*g +: 8] = line_reg[g];
    end

    // outputs
    assign BYTE_TICK_OUT     = run_tick;
    assign PAIR_SEL_OUT      = pair_reg;
    assign LINE_VALID_OUT    = lvalid_reg;
    assign LINE_FIRST_OUT    = lfirst_reg;
    assign RX_CORE_DATA_OUT  = rx_reg;
    assign RX_CORE_VALID_OUT = rvalid_reg;
    assign RX_CORE_FIRST_OUT = rfirst_reg;
    assign UNDERRUN_OUT      = under_reg;

endmodule // fcm_mapper

// ### shared/fcm_pkg.sv
// constants and types shared by the fractional core frame mapper
package fcm_pkg;

    // clock and frame timing
    localparam int CLK_HZ         = 20_000_000;          // system clock rate
    localparam int CLK_PER_US     = CLK_HZ / 1_000_000;  // cycles in one microsecond
    localparam int FRAME_US       = 500;                 // core frame length in us
    localparam int FRAME_CYC      = FRAME_US * CLK_PER_US;

    // transfer delay budget, longest times so rounded down
    localparam int DELAY_TOTAL_US = 1250;                // end to end, mean of both directions
    localparam int DELAY_TERM_US  = 450;                 // share of one termination unit
    localparam int DELAY_REG_US   = 200;                 // share of one regenerator
    localparam int DELAY_TERM_CYC = DELAY_TERM_US * CLK_PER_US;
    localparam int PIPE_CYC       = 2;                   // slot decision to line output

    // core frame layout
    localparam int CORE_BYTES     = 144;                 // bytes per core frame
    localparam int SUB_BYTES      = 36;                  // one application frame plus stuffing
    localparam int APP_BYTES      = 32;                  // time slots per application frame

    // fill pattern and special slots
    localparam logic [7:0] ALL_ONES   = 8'hFF;
    localparam logic [4:0] TS_FRAMING = 5'h00;
    localparam logic [4:0] TS_SIGNAL  = 5'h10;
    localparam logic [4:0] TS_LOW_END = 5'h0F;
    localparam logic [4:0] SLOTS_MAX  = 5'h1E;

    // line rates and pair counts
    localparam logic RATE_784   = 1'b0;
    localparam logic RATE_1168  = 1'b1;
    localparam int   PAIRS_MAX  = 3;
    localparam int   PAIRS_784  = 3;
    localparam int   PAIRS_1168 = 2;

    // mapper run state
    typedef enum logic
    {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } fcm_state_t;

    // what one application time slot carries
    typedef enum logic [1:0]
    {
        SLOT_FRAMING = 2'b00,
        SLOT_DATA    = 2'b01,
        SLOT_FILL    = 2'b10
    } fcm_slot_t;

endpackage

// ### rtl/fcm_fifo.sv
// synchronous fifo with valid and ready on both sides
module fcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // filling side
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    // draining side
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);

    localparam int AW = $clog2(DEPTH);

    // pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("fcm_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];     // storage words
    logic [AW-1:0]    wr_reg;          // write pointer
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;          // read pointer
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;         // words held
    logic [AW:0]      cnt_next;
    logic             push;            // word accepted this cycle
    logic             pop;             // word drained this cycle

    // honest flags straight from the count
    assign in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out  = mem[rd_reg];

    // next pointer and count values
    always_comb
    begin
        push     = in_valid_in & in_ready_out;
        pop      = out_valid_out & out_ready_in;
        wr_next  = push ? wr_reg + 1'b1 : wr_reg;
        rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // pointer and count registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage is not reset; the count guards every read
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data_in;
        end
    end

endmodule // fcm_fifo

// ### tb/fcm_mapper_asserts.sv
// port timing checker bound to the mapper
module fcm_chk #(
    parameter int NP     = fcm_pkg::PAIRS_MAX,
    parameter int DATA_W = 8
) (
    // clock, reset and set-up
    input wire logic                  SYS_CLK_IN,
    input wire logic                  RST_IN,
    input wire logic                  MAP_ENABLE_IN,
    input wire logic                  RATE_SEL_IN,
    input wire logic [NP-1:0]         PAIR_EQUIP_IN,
    // mapper outputs
    input wire logic                  BYTE_TICK_OUT,
    input wire logic [1:0]            PAIR_SEL_OUT,
    input wire logic [NP*DATA_W-1:0]  LINE_DATA_OUT,
    input wire logic [NP-1:0]         LINE_VALID_OUT,
    input wire logic                  LINE_FIRST_OUT,
    input wire logic [DATA_W-1:0]     RX_CORE_DATA_OUT,
    input wire logic                  RX_CORE_VALID_OUT,
    input wire logic                  RX_CORE_FIRST_OUT,
    input wire logic                  UNDERRUN_OUT
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [6:0] gap_reg;   // cycles since last tick
    logic [6:0] gap_next;
    logic       seen_reg;  // a tick seen since enable
    logic       seen_next;

    // gap counter, cleared while idle
    always_comb
    begin
        gap_next  = gap_reg + 7'h01;
        seen_next = seen_reg;
        if (BYTE_TICK_OUT)
        begin
            gap_next  = 7'h00;
            seen_next = 1'b1;
        end
        if (!MAP_ENABLE_IN)
        begin
            gap_next  = 7'h00;
            seen_next = 1'b0;
        end
    end

    // register the counter
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            gap_reg  <= 7'h00;
            seen_reg <= 1'b0;
        end
        else
        begin
            gap_reg  <= gap_next;
            seen_reg <= seen_next;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // a mapped byte and its answer
    sequence mapped_s;
        BYTE_TICK_OUT;
    endsequence
    sequence answer_s;
        RX_CORE_VALID_OUT && !BYTE_TICK_OUT;
    endsequence

    rx_answer_a: assert property (mapped_s |=> answer_s)
        else $error("no receive byte after tick");
    rx_cause_a: assert property (RX_CORE_VALID_OUT |-> $past(BYTE_TICK_OUT))
        else $error("receive strobe without tick");
    line_strobe_a: assert property (mapped_s |=> LINE_VALID_OUT == ((3'h1 << $past(PAIR_SEL_OUT)) & $past(PAIR_EQUIP_IN)))
        else $error("wrong line strobe");
    pair_two_a: assert property (mapped_s ##1 RATE_SEL_IN |-> PAIR_SEL_OUT == {1'b0, ~$past(PAIR_SEL_OUT[0])})
        else $error("two pair rotation broken");
    pair_three_a: assert property (mapped_s ##1 !RATE_SEL_IN |->
        PAIR_SEL_OUT == (($past(PAIR_SEL_OUT) == 2'h2) ? 2'h0 : $past(PAIR_SEL_OUT) + 2'h1))
        else $error("three pair rotation broken");
    first_byte_a: assert property (LINE_FIRST_OUT |-> RX_CORE_FIRST_OUT && $past(PAIR_SEL_OUT) == 2'h0)
        else $error("frame start not on pair zero");
    rx_fill_a: assert property (BYTE_TICK_OUT && !PAIR_EQUIP_IN[PAIR_SEL_OUT] |=> RX_CORE_DATA_OUT == fcm_pkg::ALL_ONES)
        else $error("unfitted pair not all ones");
    underrun_ones_a: assert property (UNDERRUN_OUT |->
        LINE_DATA_OUT[DATA_W*$past(PAIR_SEL_OUT) +: DATA_W] == fcm_pkg::ALL_ONES)
        else $error("underrun byte not all ones");
    idle_quiet_a: assert property (!MAP_ENABLE_IN |-> !BYTE_TICK_OUT)
        else $error("tick while idle");
    tick_gap_a: assert property (BYTE_TICK_OUT && seen_reg |-> gap_reg >= 7'h44)
        else $error("ticks too close");
    tick_late_a: assert property (seen_reg |-> gap_reg <= 7'h45)
        else $error("tick missing");
endmodule // fcm_chk

bind fcm_mapper fcm_chk #(.DATA_W(DATA_W)) u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .MAP_ENABLE_IN(MAP_ENABLE_IN), .RATE_SEL_IN(RATE_SEL_IN),
    .PAIR_EQUIP_IN(PAIR_EQUIP_IN), .BYTE_TICK_OUT(BYTE_TICK_OUT), .PAIR_SEL_OUT(PAIR_SEL_OUT),
    .LINE_DATA_OUT(LINE_DATA_OUT), .LINE_VALID_OUT(LINE_VALID_OUT), .LINE_FIRST_OUT(LINE_FIRST_OUT),
    .RX_CORE_DATA_OUT(RX_CORE_DATA_OUT), .RX_CORE_VALID_OUT(RX_CORE_VALID_OUT),
    .RX_CORE_FIRST_OUT(RX_CORE_FIRST_OUT), .UNDERRUN_OUT(UNDERRUN_OUT));

// ### tb/fcm_line_model.sv
// far-end line transceivers: fitted pairs echo
module fcm_line_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // pairs fitted and bytes sent
    input  wire logic [2:0]  equip_in,
    input  wire logic [23:0] line_in,
    // bytes received per pair
    output logic      [23:0] rx_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // echo one cycle late; an empty pair toggles so it never looks all ones
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rx_out <= 24'h5A_5A5A;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                rx_out[8*p +: 8] <= equip_in[p] ? line_in[8*p +: 8] : ~rx_out[8*p +: 8];
            end
        end
    end
endmodule // fcm_line_model

// ### tb/test_fractional_core_frame_mapper.sv
// self-checking bench for the frame mapper
module test_fractional_core_frame_mapper;
    timeunit 1ns;
    timeprecision 1ns;

    // mapper inputs
    logic        SYS_CLK_IN    = 1'b0;
    logic        RST_IN        = 1'b1;
    logic        MAP_ENABLE_IN = 1'b0;
    logic        RATE_SEL_IN   = 1'b0;
    logic [2:0]  PAIR_EQUIP_IN = 3'h7;
    logic [4:0]  DATA_SLOTS_IN = 5'h05;
    logic [7:0]  FRAMING_TS_IN = 8'hA5;
    logic [7:0]  USER_DATA_IN  = 8'h00;
    logic        USER_VALID_IN = 1'b0;
    logic [23:0] RX_LINE_DATA_IN;
    // mapper outputs
    logic        USER_READY_OUT, BYTE_TICK_OUT, LINE_FIRST_OUT, UNDERRUN_OUT;
    logic [1:0]  PAIR_SEL_OUT;
    logic [23:0] LINE_DATA_OUT;
    logic [2:0]  LINE_VALID_OUT;
    logic [7:0]  RX_CORE_DATA_OUT;
    logic        RX_CORE_VALID_OUT, RX_CORE_FIRST_OUT;
    // bench state
    int          n_fail     = 0;
    int          num_checks = 0;
    logic [7:0]  feed_q[$], exp_q[$], line_q[$], rx_q[$];
    logic        vld_q[$], und_q[$];
    logic        rec = 1'b0;
    logic        pend = 1'b0;
    logic [1:0]  pend_p = 2'h0;

    always #25 SYS_CLK_IN = ~SYS_CLK_IN;

    fcm_mapper #(.FIFO_DEPTH(32), .DATA_W(8)) u_dut (
        .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .MAP_ENABLE_IN(MAP_ENABLE_IN), .RATE_SEL_IN(RATE_SEL_IN),
        .PAIR_EQUIP_IN(PAIR_EQUIP_IN), .DATA_SLOTS_IN(DATA_SLOTS_IN), .FRAMING_TS_IN(FRAMING_TS_IN),
        .USER_DATA_IN(USER_DATA_IN), .USER_VALID_IN(USER_VALID_IN), .USER_READY_OUT(USER_READY_OUT),
        .BYTE_TICK_OUT(BYTE_TICK_OUT), .PAIR_SEL_OUT(PAIR_SEL_OUT), .LINE_DATA_OUT(LINE_DATA_OUT),
        .LINE_VALID_OUT(LINE_VALID_OUT), .LINE_FIRST_OUT(LINE_FIRST_OUT), .RX_LINE_DATA_IN(RX_LINE_DATA_IN),
        .RX_CORE_DATA_OUT(RX_CORE_DATA_OUT), .RX_CORE_VALID_OUT(RX_CORE_VALID_OUT),
        .RX_CORE_FIRST_OUT(RX_CORE_FIRST_OUT), .UNDERRUN_OUT(UNDERRUN_OUT));

    fcm_line_model u_line (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .equip_in(PAIR_EQUIP_IN),
        .line_in(LINE_DATA_OUT), .rx_out(RX_LINE_DATA_IN));

    // feeder holds each word until taken
    always @(posedge SYS_CLK_IN)
    begin
        if (!RST_IN && USER_VALID_IN && USER_READY_OUT)
        begin
            void'(feed_q.pop_front());
        end
        USER_VALID_IN <= !RST_IN && (feed_q.size() > 0);
        USER_DATA_IN  <= (feed_q.size() > 0) ? feed_q[0] : 8'h00;
    end

    // monitor: results land one cycle after the tick
    always @(posedge SYS_CLK_IN)
    begin
        if (pend && rec && (line_q.size() > 0 || LINE_FIRST_OUT))
        begin
            line_q.push_back(LINE_DATA_OUT[8*pend_p +: 8]);
            vld_q.push_back(LINE_VALID_OUT[pend_p]);
            rx_q.push_back(RX_CORE_DATA_OUT);
            und_q.push_back(UNDERRUN_OUT);
        end
        pend   = BYTE_TICK_OUT;
        pend_p = PAIR_SEL_OUT;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // 5-cycle reset with a new set-up; reset values checked
    task automatic restart(input logic rate, input logic [2:0] eq, input logic [4:0] n, input logic en);
        @(posedge SYS_CLK_IN);
        RST_IN        <= 1'b1;
        RATE_SEL_IN   <= rate;
        PAIR_EQUIP_IN <= eq;
        DATA_SLOTS_IN <= n;
        MAP_ENABLE_IN <= en;
        @(negedge SYS_CLK_IN);
        feed_q = {};
        exp_q  = {};
        line_q = {};
        rx_q   = {};
        vld_q  = {};
        und_q  = {};
        repeat (4) @(negedge SYS_CLK_IN);
        check({4'h0, USER_READY_OUT, BYTE_TICK_OUT, |LINE_VALID_OUT, &LINE_DATA_OUT}, 8'h09);
        check(RX_CORE_DATA_OUT, 8'hFF);
        @(posedge SYS_CLK_IN);
        RST_IN <= 1'b0;
    endtask

    // queue words for buffer and expectation
    task automatic offer(input int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            feed_q.push_back(8'(i * 7 + 1));
            exp_q.push_back(8'(i * 7 + 1));
        end
    endtask

    task automatic capture(input int nb);
        @(negedge SYS_CLK_IN);
        rec = 1'b1;
        for (int i = 0; i < (nb / 144 + 1) * 10100 && line_q.size() < nb; i++)
        begin
            @(negedge SYS_CLK_IN);
        end
        rec = 1'b0;
        check({7'h0, line_q.size() >= nb}, 8'h01);
    endtask

    // compare captured bytes with the slot map
    task automatic judge(input int np, input logic [2:0] eq, input int n, input int nb);
        int pos, nn;
        logic d, u;
        logic [7:0] e;
        nn = (n > 30) ? 30 : n;
        for (int k = 0; k < nb && k < line_q.size(); k++)
        begin
            pos = k % 36;
            d = (pos >= 1 && pos <= 31 && pos != 16) && (pos <= ((nn <= 15) ? nn : nn + 1));
            u = d && (exp_q.size() == 0);
            e = (pos == 0) ? FRAMING_TS_IN : 8'hFF;
            if (d && !u)
            begin
                e = exp_q.pop_front();
            end
            check(line_q[k], e);
            check({7'h0, und_q[k]}, {7'h0, u});
            check({7'h0, vld_q[k]}, {7'h0, eq[k % np]});
            if (k >= np)
            begin
                check(rx_q[k], eq[k % np] ? line_q[k - np] : 8'hFF);
            end
        end
    endtask

    // fill while idle, 33rd word refused, drain over two frames
    task automatic t_fill;
        restart(fcm_pkg::RATE_784, 3'h7, 5'h05, 1'b0);
        offer(33);
        repeat (45) @(negedge SYS_CLK_IN);
        check({7'h0, USER_READY_OUT}, 8'h00);
        check(8'(feed_q.size()), 8'h01);
        @(posedge SYS_CLK_IN);
        MAP_ENABLE_IN <= 1'b1;
        capture(288);
        judge(3, 3'h7, 5, 288);
        check({7'h0, USER_READY_OUT}, 8'h01);
        $display("t_fill done");
    endtask

    // two pairs, pair 1 unfitted, 31 slots clamp to 30
    task automatic t_two;
        restart(fcm_pkg::RATE_1168, 3'h1, 5'h1F, 1'b1);
        offer(130);
        capture(144);
        judge(2, 3'h1, 31, 144);
        $display("t_two done");
    endtask

    // pair 1 unfitted, 15 slots, then a mid-frame stop
    task automatic t_part;
        restart(fcm_pkg::RATE_784, 3'h5, 5'h0F, 1'b1);
        offer(60);
        capture(144);
        judge(3, 3'h5, 15, 144);
        repeat (300) @(posedge SYS_CLK_IN);
        MAP_ENABLE_IN <= 1'b0;
        repeat (100) @(posedge SYS_CLK_IN);
        MAP_ENABLE_IN <= 1'b1;
        for (int i = 0; i < 80 && BYTE_TICK_OUT !== 1'b1; i++)
        begin
            @(negedge SYS_CLK_IN);
        end
        @(negedge SYS_CLK_IN);
        check({7'h0, LINE_FIRST_OUT}, 8'h01);
        $display("t_part done");
    endtask

    // main sequence
    initial
    begin
        t_fill;
        t_two;
        t_part;
        tally_and_finish;
    end

    // watchdog: tests need about 2 ms
    initial
    begin
        #4_000_000;
        n_fail++;
        tally_and_finish;
    end
endmodule // test_fractional_core_frame_mapper
